// [cpu_side_model.sv]
module cpu_side_model (
	// clock
	input wire logic ref_clk,
	// requests from the bench
	input wire logic [6:0] want_code,
	input wire logic want_pgd,
	// pins toward the controller
	output logic [6:0] voltage_id_code = 7'h00,
	output logic system_power_good_in = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;

	// code lines always driven, never left floating
	always @(posedge ref_clk) begin
		voltage_id_code <= want_code;
		system_power_good_in <= want_pgd;
	end
endmodule : cpu_side_model

// [vid_seq_pkg.sv]
package vid_seq_pkg;

	// ------------------------------------------------------------
	// identification code
	// ------------------------------------------------------------
	localparam int VID_W = 7;
	localparam logic [6:0] VID_OFF_CODE = 7'h7F;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int SLEW_DIV_NORMAL = 1;
	localparam int SLEW_DIV_FALLBACK = 4;
	localparam logic [1:0] SLEW_CNT_ZERO = 2'h0;
	localparam logic [1:0] SLEW_CNT_LAST = 2'h3;

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_OFF = 6'h01,
		ST_SOFT_START = 6'h02,
		ST_BOOT_HOLD = 6'h04,
		ST_RUN = 6'h08,
		ST_FALLBACK = 6'h10,
		ST_SOFT_STOP = 6'h20
	} seq_state_t;

	// ------------------------------------------------------------
	// gate drive request from the modulator, per phase
	// ------------------------------------------------------------
	typedef struct packed {
		logic high_req;
		logic low_req;
		logic zero_cross;
	} phase_req_t;

	// ------------------------------------------------------------
	// analog status indications
	// ------------------------------------------------------------
	typedef struct packed {
		logic over_volt;
		logic neg_ilim;
		logic thermal_sense;
		logic soft_start_done;
		logic output_at_zero;
		logic output_at_target;
	} analog_stat_t;

endpackage : vid_seq_pkg

// [vid_sequencer_driver_ctrl.sv]
module vid_sequencer_driver_ctrl (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// processor and system inputs
	input wire logic [6:0] voltage_id_code,
	input wire logic system_power_good_in,
	input wire logic power_off_n,
	input wire logic skip_mode_sel,
	input wire logic phase3_enable,
	// modulator requests and analog status
	input wire vid_seq_pkg::phase_req_t ph1_req,
	input wire vid_seq_pkg::phase_req_t ph2_req,
	input wire logic phase3_req,
	input wire vid_seq_pkg::analog_stat_t analog_stat,
	// sequencing outputs
	output logic cpu_clock_go_n,
	output logic output_good,
	output logic [6:0] target_code,
	output logic use_boot_level,
	output logic slew_step_en,
	output logic regulator_on,
	// gate drives
	output logic phase1_high_drive,
	output logic phase1_low_drive,
	output logic phase2_high_drive,
	output logic phase2_low_drive,
	output logic phase1_boost_charge,
	output logic phase2_boost_charge,
	output logic ext_driver_skip,
	output logic phase3_pulse_o,
	output logic phase3_pulse_oe,
	output logic thermal_alert_n_o,
	output logic thermal_alert_n_oe
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [8:0] sync1_ff;
	logic [8:0] sync2_ff;
	logic [6:0] vid_s;
	logic pgd_s;
	logic pwr_on_s;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= 9'h000;
			sync2_ff <= 9'h000;
		end else begin
			sync1_ff <= {power_off_n, system_power_good_in, voltage_id_code};
			sync2_ff <= sync1_ff;
		end
	end

	assign vid_s = sync2_ff[6:0];
	assign pgd_s = sync2_ff[7];
	assign pwr_on_s = sync2_ff[8];

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic logic is_off_code(input logic [6:0] c);
		is_off_code = (c == vid_seq_pkg::VID_OFF_CODE);
	endfunction : is_off_code

	logic code_off;
	logic enable_req;
	assign code_off = is_off_code(vid_s);
	assign enable_req = pwr_on_s && !code_off;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	vid_seq_pkg::seq_state_t state_ff;
	vid_seq_pkg::seq_state_t nxt_state;
	logic [1:0] slew_cnt_ff;
	logic [1:0] nxt_slew_cnt;
	logic st_off;
	logic st_start;
	logic st_hold;
	logic st_run;
	logic st_fall;
	logic st_stop;

	assign st_off = (state_ff == vid_seq_pkg::ST_OFF);
	assign st_start = (state_ff == vid_seq_pkg::ST_SOFT_START);
	assign st_hold = (state_ff == vid_seq_pkg::ST_BOOT_HOLD);
	assign st_run = (state_ff == vid_seq_pkg::ST_RUN);
	assign st_fall = (state_ff == vid_seq_pkg::ST_FALLBACK);
	assign st_stop = (state_ff == vid_seq_pkg::ST_SOFT_STOP);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			vid_seq_pkg::ST_OFF: begin
				if (enable_req)
					nxt_state = vid_seq_pkg::ST_SOFT_START;
			end
			vid_seq_pkg::ST_SOFT_START: begin
				if (!enable_req)
					nxt_state = vid_seq_pkg::ST_SOFT_STOP;
				else if (analog_stat.soft_start_done)
					nxt_state = vid_seq_pkg::ST_BOOT_HOLD;
			end
			vid_seq_pkg::ST_BOOT_HOLD: begin
				if (!enable_req)
					nxt_state = vid_seq_pkg::ST_SOFT_STOP;
				else if (pgd_s)
					nxt_state = vid_seq_pkg::ST_RUN;
			end
			vid_seq_pkg::ST_RUN: begin
				if (!enable_req)
					nxt_state = vid_seq_pkg::ST_SOFT_STOP;
				else if (!pgd_s)
					nxt_state = vid_seq_pkg::ST_FALLBACK;
			end
			vid_seq_pkg::ST_FALLBACK: begin
				if (!enable_req)
					nxt_state = vid_seq_pkg::ST_SOFT_STOP;
				else if (pgd_s)
					nxt_state = vid_seq_pkg::ST_RUN;
			end
			vid_seq_pkg::ST_SOFT_STOP: begin
				if (analog_stat.output_at_zero)
					nxt_state = vid_seq_pkg::ST_OFF;
			end
			default: nxt_state = vid_seq_pkg::ST_OFF;
		endcase
	end

	// quarter-rate slew enable while falling back
	assign nxt_slew_cnt = st_fall ? (slew_cnt_ff + 2'h1) : vid_seq_pkg::SLEW_CNT_ZERO;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= vid_seq_pkg::ST_OFF;
			slew_cnt_ff <= vid_seq_pkg::SLEW_CNT_ZERO;
		end else begin
			state_ff <= nxt_state;
			slew_cnt_ff <= nxt_slew_cnt;
		end
	end

	// ------------------------------------------------------------
	// sequencing outputs
	// ------------------------------------------------------------
	logic clk_go_n_ff;
	logic good_ff;
	logic [6:0] target_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_go_n_ff <= 1'h1;
			good_ff <= 1'h0;
			target_ff <= 7'h00;
		end else begin
			// dropped one cycle after power-good is seen low on pgd_s
			clk_go_n_ff <= !(st_run && pgd_s && enable_req && analog_stat.output_at_target);
			good_ff <= st_run && pgd_s && enable_req && analog_stat.output_at_target;
			if (st_run && !code_off)
				target_ff <= vid_s;
		end
	end

	assign cpu_clock_go_n = clk_go_n_ff;
	assign output_good = good_ff;
	assign target_code = target_ff;
	assign use_boot_level = st_start || st_hold || st_fall;
	assign slew_step_en = st_fall ? (slew_cnt_ff == vid_seq_pkg::SLEW_CNT_LAST) : !st_off;
	assign regulator_on = !st_off;

	// ------------------------------------------------------------
	// gate drive overrides
	// ------------------------------------------------------------
	logic shut;
	logic skip_active;
	logic [1:0] hi_req;
	logic [1:0] lo_req;
	logic [1:0] zc;
	logic [1:0] hi_drv;
	logic [1:0] lo_drv;

	assign shut = st_off;
	assign skip_active = skip_mode_sel || st_fall;
	assign hi_req = {ph2_req.high_req, ph1_req.high_req};
	assign lo_req = {ph2_req.low_req, ph1_req.low_req};
	assign zc = {ph2_req.zero_cross, ph1_req.zero_cross};

	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++) begin : g_phase
			assign hi_drv[gp] = !shut && !analog_stat.over_volt && hi_req[gp];
			assign lo_drv[gp] = shut ? 1'h0 :
				analog_stat.over_volt ? 1'h1 :
				(skip_active && zc[gp]) ? 1'h0 :
				lo_req[gp];
		end
	endgenerate

	assign phase1_high_drive = hi_drv[0];
	assign phase2_high_drive = hi_drv[1];
	assign phase1_low_drive = lo_drv[0];
	assign phase2_low_drive = lo_drv[1];
	assign phase1_boost_charge = lo_drv[0];
	assign phase2_boost_charge = lo_drv[1];
	assign ext_driver_skip = !shut && !skip_active;
	assign phase3_pulse_oe = !shut && phase3_enable;
	assign phase3_pulse_o = phase3_pulse_oe && phase3_req;
	assign thermal_alert_n_o = 1'h0;
	assign thermal_alert_n_oe = !shut && analog_stat.thermal_sense;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_HI_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
		st_off |-> !phase1_high_drive && !phase2_high_drive) else $error("high drive in shutdown");
	AST_LO_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
		st_off |-> !phase1_low_drive && !phase2_low_drive) else $error("low drive in shutdown");
	AST_OVP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!st_off && analog_stat.over_volt) |-> phase1_low_drive && phase2_low_drive)
		else $error("overvoltage did not force low drives");
	AST_ZC: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(skip_active && ph1_req.zero_cross && !analog_stat.over_volt) |-> !phase1_low_drive)
		else $error("low drive after zero crossing");
	AST_HOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		thermal_alert_n_oe |-> !st_off && analog_stat.thermal_sense) else $error("alert wrong");
	AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
		st_hold |=> cpu_clock_go_n && !output_good) else $error("boot hold outputs");
	AST_PGD_FALL: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_run && enable_req && !pgd_s) |=> cpu_clock_go_n && !output_good && st_fall)
		else $error("power-good fall not handled");
	AST_QUARTER: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_fall && slew_step_en) |=> (!st_fall || !slew_step_en) [*3])
		else $error("fallback slew rate");
	AST_CODE_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_run && code_off) |=> st_stop) else $error("off code ignored");
	AST_BOOST: assert property (@(posedge ref_clk) disable iff (!rst_n)
		phase1_boost_charge |-> phase1_low_drive) else $error("boost without low drive");
	AST_SYNC: assert property (@(posedge ref_clk) disable iff (!rst_n)
		vid_s == $past(sync1_ff[6:0])) else $error("sync stage");
	AST_PH3: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_off || !phase3_enable) |-> !phase3_pulse_oe) else $error("phase three driven");
	AST_HOLD_STAY: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_hold && enable_req && !pgd_s) |=> st_hold && use_boot_level)
		else $error("boot hold left early");
	AST_RUN_GO: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_run && pgd_s && enable_req && analog_stat.output_at_target)
		|=> !cpu_clock_go_n && output_good) else $error("clock enable not given");
	AST_TARGET: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_run && !code_off) |=> target_code == $past(vid_s)) else $error("target not followed");
	AST_FALL_STAY: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_fall && enable_req && !pgd_s) |=> st_fall && use_boot_level)
		else $error("fallback left early");
	AST_STOP_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_stop && analog_stat.output_at_zero) |=> st_off) else $error("soft stop did not end");
	AST_OFF_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
		st_off |-> !ext_driver_skip && !phase3_pulse_oe && !phase3_pulse_o)
		else $error("skip or phase three active in shutdown");
	AST_RESTART: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_off && enable_req) |=> st_start) else $error("startup not begun");
	AST_CODE_WATCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_off && code_off) |=> st_off) else $error("off code did not hold shutdown");
	AST_BOOST2: assert property (@(posedge ref_clk) disable iff (!rst_n)
		phase2_boost_charge |-> phase2_low_drive) else $error("boost without low drive");
	AST_ZC2: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(skip_active && ph2_req.zero_cross && !analog_stat.over_volt) |-> !phase2_low_drive)
		else $error("low drive after zero crossing");
	AST_HOT_ON: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!st_off && analog_stat.thermal_sense) |-> thermal_alert_n_oe && !thermal_alert_n_o)
		else $error("alert not pulled low");
	AST_SKIP_FORCED: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!st_off && !skip_mode_sel && !st_fall) |-> ext_driver_skip)
		else $error("skip control not high");
	AST_SKIP_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(skip_mode_sel || st_fall) |-> !ext_driver_skip) else $error("skip control not low");
	AST_QUARTER_DUE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_fall && slew_step_en) ##1 st_fall [*4] |-> slew_step_en)
		else $error("fallback slew step missing");

	COV_START: cover property (@(posedge ref_clk) disable iff (!rst_n) st_hold ##1 st_run);
	COV_FALL: cover property (@(posedge ref_clk) disable iff (!rst_n) st_run ##1 st_fall);
	COV_STOP: cover property (@(posedge ref_clk) disable iff (!rst_n) st_stop ##1 st_off);
	COV_OVP: cover property (@(posedge ref_clk) disable iff (!rst_n) st_run && analog_stat.over_volt);
	COV_RESTART: cover property (@(posedge ref_clk) disable iff (!rst_n) st_off ##1 st_start);

endmodule : vid_sequencer_driver_ctrl

// [vid_sequencer_driver_ctrl_bench.sv]
module vid_sequencer_driver_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] want_code = 7'h00;
	logic want_pgd = 1'b0;
	logic [6:0] vid;
	logic pgd;
	logic power_off_n = 1'b0;
	logic skip_sel = 1'b0;
	logic ph3_en = 1'b0;
	logic ph3_req = 1'b0;
	vid_seq_pkg::phase_req_t ph1 = 3'h0;
	vid_seq_pkg::phase_req_t ph2 = 3'h0;
	vid_seq_pkg::analog_stat_t ana = 6'h00;
	logic go_n, good, boot, step, on, h1, l1, h2, l2, b1, b2, skp, p3o, p3oe, tho, thoe;
	logic [6:0] tgt;
	int err_total = 0;
	int num_checks = 0;
	wire [2:0] mon = {good, go_n, on};

	always #5 ref_clk = ~ref_clk;

	cpu_side_model cpu (.ref_clk(ref_clk), .want_code(want_code), .want_pgd(want_pgd),
		.voltage_id_code(vid), .system_power_good_in(pgd));

	vid_sequencer_driver_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .voltage_id_code(vid),
		.system_power_good_in(pgd), .power_off_n(power_off_n), .skip_mode_sel(skip_sel),
		.phase3_enable(ph3_en), .ph1_req(ph1), .ph2_req(ph2), .phase3_req(ph3_req),
		.analog_stat(ana), .cpu_clock_go_n(go_n), .output_good(good), .target_code(tgt),
		.use_boot_level(boot), .slew_step_en(step), .regulator_on(on),
		.phase1_high_drive(h1), .phase1_low_drive(l1), .phase2_high_drive(h2),
		.phase2_low_drive(l2), .phase1_boost_charge(b1), .phase2_boost_charge(b2),
		.ext_driver_skip(skp), .phase3_pulse_o(p3o), .phase3_pulse_oe(p3oe),
		.thermal_alert_n_o(tho), .thermal_alert_n_oe(thoe));

	task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	task automatic edges(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : edges

	// bounded wait on one monitored flag
	task automatic wait_mon(input int idx, input logic val);
		for (int i = 0; i < 40; i++) begin
			edges(1);
			if (mon[idx] === val) return;
		end
		err_total++;
		$display("wrong value wait %0d expected %b seen %b", idx, val, mon[idx]);
		end_sim();
	endtask : wait_mon

	task automatic t_reset;
		ph1 <= 3'h6;
		ph2 <= 3'h6;
		ph3_en <= 1'b1;
		ph3_req <= 1'b1;
		ana <= 6'h28;
		edges(6);
		check("drives", {h1, h2, l1, l2, skp, p3oe, thoe}, 7'h00);
		check("go_good", {go_n, good, p3o, on}, 7'h08);
		ph1 <= 3'h0;
		ph2 <= 3'h0;
		ph3_en <= 1'b0;
		ph3_req <= 1'b0;
		ana <= 6'h00;
		$display("test reset done");
	endtask : t_reset

	task automatic t_startup;
		power_off_n <= 1'b1;
		want_code <= 7'h15;
		wait_mon(0, 1'b1);
		check("boot", boot, 1'b1);
		ana.soft_start_done <= 1'b1;
		edges(8);
		check("hold", {go_n, good, boot}, 7'h05);
		want_pgd <= 1'b1;
		ana.output_at_target <= 1'b1;
		wait_mon(2, 1'b1);
		check("run_go_boot", {go_n, boot}, 7'h00);
		check("run_tgt", tgt, 7'h15);
		check("run_step", step, 7'h01);
		$display("test startup done");
	endtask : t_startup

	task automatic t_drives;
		ph1 <= 3'h4;
		ph2 <= 3'h2;
		edges(2);
		check("forced", {h1, l1, h2, l2, b1, b2, skp}, 7'h4B);
		ph1 <= 3'h0;
		ph2 <= 3'h0;
		ana.over_volt <= 1'b1;
		ana.neg_ilim <= 1'b1;
		edges(2);
		check("ovp", {l1, l2}, 7'h03);
		ana.over_volt <= 1'b0;
		ana.neg_ilim <= 1'b0;
		skip_sel <= 1'b1;
		ph1 <= 3'h3;
		ph2 <= 3'h2;
		ana.thermal_sense <= 1'b1;
		ph3_en <= 1'b1;
		ph3_req <= 1'b1;
		edges(2);
		check("skip", {l1, l2, skp}, 7'h02);
		check("hot", {thoe, tho, p3oe, p3o}, 7'h0B);
		ph3_en <= 1'b0;
		skip_sel <= 1'b0;
		edges(2);
		check("ph3off", p3oe, 1'b0);
		$display("test drives done");
	endtask : t_drives

	task automatic t_fallback;
		int cnt;
		want_pgd <= 1'b0;
		edges(2);
		check("sync", go_n, 1'b0);
		wait_mon(1, 1'b1);
		check("fall", {good, boot, skp}, 7'h02);
		cnt = 0;
		for (int i = 0; i < 8; i++) begin
			edges(1);
			cnt += (step === 1'b1);
		end
		check("quarter", cnt[6:0], 7'h02);
		edges(20);
		check("stay", {boot, good}, 7'h02);
		want_pgd <= 1'b1;
		wait_mon(2, 1'b1);
		check("back", go_n, 1'b0);
		$display("test fallback done");
	endtask : t_fallback

	task automatic t_code_off;
		want_code <= vid_seq_pkg::VID_OFF_CODE;
		ana.output_at_zero <= 1'b1;
		ana.output_at_target <= 1'b0;
		ph1 <= 3'h6;
		ph2 <= 3'h6;
		ph3_en <= 1'b1;
		wait_mon(0, 1'b0);
		check("off", {h1, h2, l1, l2, skp, p3oe, thoe}, 7'h00);
		want_code <= 7'h20;
		ana.output_at_zero <= 1'b0;
		wait_mon(0, 1'b1);
		check("restart", {boot, go_n, good}, 7'h06);
		$display("test code shutdown done");
	endtask : t_code_off

	initial begin
		t_reset();
		rst_n <= 1'b0;
		edges(6);
		rst_n <= 1'b1;
		t_startup();
		t_drives();
		t_fallback();
		t_code_off();
		end_sim();
	end
endmodule : vid_sequencer_driver_ctrl_bench
